// ==== usi_pkg.sv ====
// Package with the register map, field layout and types of the USART slice.
package usi_pkg;

  // Register byte addresses on the AXI4-Lite port.
  localparam logic [31:0] ADDR_MODE = 32'h4002_4000;
  localparam logic [31:0] ADDR_IER  = 32'h4002_4008;
  localparam logic [31:0] ADDR_IRQ_DISABLE_SPI_VIEW = 32'h4002_400C;
  localparam logic [31:0] ADDR_IMR  = 32'h4002_4010;
  localparam logic [31:0] ADDR_ISR  = 32'h4002_4014;
  localparam logic [31:0] ADDR_ISO_BAUD_RATIO = 32'h4002_4040;
  localparam logic [31:0] ADDR_WPMR = 32'h4002_40E4;

  // Interrupt source bit positions, shared by enable, disable, mask, status.
  localparam int unsigned BIT_RX_READY   = 0;
  localparam int unsigned BIT_TX_READY   = 1;
  localparam int unsigned BIT_RX_END     = 3;
  localparam int unsigned BIT_TX_END     = 4;
  localparam int unsigned BIT_OVERRUN    = 5;
  localparam int unsigned BIT_TX_EMPTY   = 9;
  localparam int unsigned BIT_UNDERRUN   = 10;
  localparam int unsigned BIT_TXBUF_EMPT = 11;
  localparam int unsigned BIT_RXBUF_FULL = 12;
  localparam logic [31:0] IRQ_VALID      = 32'h0000_1E3B;

  // Operating mode field.
  localparam int unsigned MODE_W          = 4;
  localparam logic [3:0]  MODE_SPI_MASTER = 4'hE;
  localparam logic [3:0]  MODE_SPI_SLAVE  = 4'hF;
  localparam logic [3:0]  MODE_ISO7816    = 4'h4;
  localparam logic [3:0]  MODE_RST        = 4'h0;

  // Baud ratio field.
  localparam int unsigned RATIO_W   = 11;
  localparam logic [10:0] RATIO_RST = 11'h000;
  localparam logic [10:0] RATIO_MIN = 11'h003;

  // Write protection enable position in its mode register.
  localparam int unsigned WP_ENABLE_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt events from the rest of the USART, one-cycle pulses or levels.
  typedef struct packed {
    logic receive_buffer_full;
    logic transmit_buffer_empty;
    logic underrun_error;
    logic transmitter_empty;
    logic overrun_error;
    logic transmit_transfer_end;
    logic receive_transfer_end;
    logic transmitter_ready;
    logic receiver_ready;
  } usi_evt_type;

endpackage

// ==== usi_usart_slice.sv ====
// AXI4-Lite register slice: interrupt disable, mask, status and ISO baud gen.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module usi_usart_slice (
  input  wire logic                 core_clk_i,
  input  wire logic                 srst_i,
  input  wire logic [31:0]          s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [31:0]          s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 rready_unused_guard_i,
  input  wire usi_pkg::usi_evt_type irq_evt_i,
  input  wire logic                 sck_i,
  output logic [3:0]                mode_o,
  output logic                      baud_tick_o,
  output logic                      irq_o
);

  logic        aw_got_q;
  logic        w_got_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [31:0] evt_vec;
  logic [31:0] mask_q;
  logic [31:0] status_q;
  logic [3:0]  mode_q;
  logic        write_protect_enable_q;
  logic [31:0] ratio_wr;
  logic [10:0] ratio_q;
  logic [10:0] cnt_q;
  logic        sck_s1_q;
  logic        sck_s2_q;
  logic        sck_s3_q;
  logic        spi_mode;
  logic        iso_mode;

  // Byte lanes that the strobe leaves out keep the old value.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] word_addr(input logic [31:0] a);
    return {a[31:2], 2'h0};
  endfunction

  function automatic logic strb_low(input logic [3:0] strb);
    return strb[0];
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    logic [31:0] w;
    w = word_addr(a);
    return (w == usi_pkg::ADDR_MODE) || (w == usi_pkg::ADDR_IER) ||
           (w == usi_pkg::ADDR_IRQ_DISABLE_SPI_VIEW) ||
           (w == usi_pkg::ADDR_IMR) || (w == usi_pkg::ADDR_ISR) ||
           (w == usi_pkg::ADDR_ISO_BAUD_RATIO) ||
           (w == usi_pkg::ADDR_WPMR);
  endfunction

  assign spi_mode = (mode_q == usi_pkg::MODE_SPI_MASTER) ||
                    (mode_q == usi_pkg::MODE_SPI_SLAVE);
  assign iso_mode = (mode_q == usi_pkg::MODE_ISO7816);
  assign wr_fire  = aw_got_q && w_got_q && !s_axi_bvalid_o;
  assign wr_hit   = mapped(awaddr_q);
  assign rd_hit   = mapped(s_axi_araddr_i);
  // Disable and enable act only on the bits the active layout defines.
  assign wr_word  = wdata_q & usi_pkg::IRQ_VALID &
                    ~(spi_mode ? 32'h0000_0000 :
                      (32'h0000_0001 << usi_pkg::BIT_UNDERRUN));

  always_comb begin
    evt_vec = 32'h0000_0000;
    evt_vec[usi_pkg::BIT_RX_READY]   = irq_evt_i.receiver_ready;
    evt_vec[usi_pkg::BIT_RX_END]     = irq_evt_i.receive_transfer_end;
    evt_vec[usi_pkg::BIT_OVERRUN]    = irq_evt_i.overrun_error;
    evt_vec[usi_pkg::BIT_RXBUF_FULL] = irq_evt_i.receive_buffer_full;
    evt_vec[usi_pkg::BIT_TX_READY]   = irq_evt_i.transmitter_ready;
    evt_vec[usi_pkg::BIT_TX_END]     = irq_evt_i.transmit_transfer_end;
    evt_vec[usi_pkg::BIT_TX_EMPTY]   = irq_evt_i.transmitter_empty;
    evt_vec[usi_pkg::BIT_TXBUF_EMPT] = irq_evt_i.transmit_buffer_empty;
    evt_vec[usi_pkg::BIT_UNDERRUN]   = irq_evt_i.underrun_error & spi_mode;
  end

  // Write channel: address and data are caught separately, in either order.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      aw_got_q        <= 1'b0;
      s_axi_awready_o <= 1'b0;
      awaddr_q        <= 32'h0000_0000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got_q        <= 1'b1;
      s_axi_awready_o <= 1'b0;
      awaddr_q        <= s_axi_awaddr_i;
    end else begin
      if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      s_axi_awready_o <= s_axi_awvalid_i && !aw_got_q && !s_axi_bvalid_o;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      w_got_q        <= 1'b0;
      s_axi_wready_o <= 1'b0;
      wdata_q        <= 32'h0000_0000;
      wstrb_q        <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got_q        <= 1'b1;
      s_axi_wready_o <= 1'b0;
      wdata_q        <= s_axi_wdata_i;
      wstrb_q        <= s_axi_wstrb_i;
    end else begin
      if (wr_fire) begin
        w_got_q <= 1'b0;
      end
      s_axi_wready_o <= s_axi_wvalid_i && !w_got_q && !s_axi_bvalid_o;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= usi_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? usi_pkg::RESP_OKAY : usi_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_q <= usi_pkg::MODE_RST;
      write_protect_enable_q <= 1'b0;
    end else if (wr_fire && strb_low(wstrb_q)) begin
      if (word_addr(awaddr_q) == usi_pkg::ADDR_MODE) begin
        mode_q <= wdata_q[usi_pkg::MODE_W-1:0];
      end
      if (word_addr(awaddr_q) == usi_pkg::ADDR_WPMR) begin
        write_protect_enable_q <= wdata_q[usi_pkg::WP_ENABLE_BIT];
      end
    end
  end

  // Protected writes complete with OKAY but leave the ratio untouched.
  assign ratio_wr = merge({21'h00_0000, ratio_q}, wdata_q, wstrb_q);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ratio_q <= usi_pkg::RATIO_RST;
    end else if (wr_fire && !write_protect_enable_q &&
                 word_addr(awaddr_q) == usi_pkg::ADDR_ISO_BAUD_RATIO) begin
      ratio_q <= ratio_wr[usi_pkg::RATIO_W-1:0];
    end
  end

  // Mask: enable writes set bits, disable writes clear them.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mask_q <= 32'h0000_0000;
    end else if (wr_fire && wstrb_q == 4'hF) begin
      if (word_addr(awaddr_q) == usi_pkg::ADDR_IER) begin
        mask_q <= mask_q | wr_word;
      end
      if (word_addr(awaddr_q) == usi_pkg::ADDR_IRQ_DISABLE_SPI_VIEW) begin
        mask_q <= mask_q & ~wr_word;
      end
    end
  end

  // Sticky status, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      status_q <= 32'h0000_0000;
    end else if (wr_fire && wstrb_q == 4'hF &&
                 word_addr(awaddr_q) == usi_pkg::ADDR_ISR) begin
      status_q <= (status_q & ~wdata_q) | evt_vec;
    end else begin
      status_q <= status_q | evt_vec;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  // Read channel.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_addr(s_axi_araddr_i))
      usi_pkg::ADDR_MODE: rd_word[usi_pkg::MODE_W-1:0] = mode_q;
      usi_pkg::ADDR_IMR:  rd_word = mask_q;
      usi_pkg::ADDR_ISR:  rd_word = status_q;
      usi_pkg::ADDR_ISO_BAUD_RATIO: rd_word[usi_pkg::RATIO_W-1:0] = ratio_q;
      usi_pkg::ADDR_WPMR: rd_word[usi_pkg::WP_ENABLE_BIT] =
                            write_protect_enable_q;
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= usi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= rd_hit ? usi_pkg::RESP_OKAY : usi_pkg::RESP_SLVERR;
    end else begin
      if (s_axi_rvalid_o && rready_unused_guard_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
      s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o &&
                         !s_axi_rvalid_o;
    end
  end

  // Serial clock pin comes from outside, so it is synchronised first.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // The divider counts rising edges of the pin clock, so that clock must be
  // well below half the core clock or edges are lost.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q       <= 11'h000;
      baud_tick_o <= 1'b0;
    end else if (!iso_mode || ratio_q == 11'h000) begin
      cnt_q       <= 11'h000;
      baud_tick_o <= 1'b0;
    end else if (sck_s2_q && !sck_s3_q) begin
      if (cnt_q + 11'h001 >= ratio_q) begin
        cnt_q       <= 11'h000;
        baud_tick_o <= 1'b1;
      end else begin
        cnt_q       <= cnt_q + 11'h001;
        baud_tick_o <= 1'b0;
      end
    end else begin
      baud_tick_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mode_o <= usi_pkg::MODE_RST;
    end else begin
      mode_o <= mode_q;
    end
  end

endmodule

// ==== usi_chk_sva.sv ====
// Checker on the register port, interrupt and baud tick of the slice.
`timescale 1ns/1ps
module usi_chk (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        sck_i,
  input wire logic [3:0]  mode_o,
  input wire logic        baud_tick_o,
  input wire logic        irq_o
);
  logic [10:0] rat_q;
  logic [2:0]  age_q;
  logic        wp_q, off_q, sck_q, wd, sel_idr;
  // The master holds address and data until its next request, so the
  // response handshake still sees the values of the write that it ends.
  assign wd = s_axi_bvalid_o && s_axi_bready_i;
  assign sel_idr = wd && s_axi_awaddr_i == usi_pkg::ADDR_IRQ_DISABLE_SPI_VIEW
    && s_axi_wdata_i == usi_pkg::IRQ_VALID && mode_o[3:1] == 3'h7;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rat_q <= '0;
      wp_q  <= 1'b0;
      off_q <= 1'b0;
    end else if (wd) begin
      if (s_axi_awaddr_i == usi_pkg::ADDR_WPMR) wp_q <= s_axi_wdata_i[0];
      if (s_axi_awaddr_i == usi_pkg::ADDR_ISO_BAUD_RATIO && !wp_q)
        rat_q <= s_axi_wdata_i[10:0];
      if (s_axi_awaddr_i == usi_pkg::ADDR_IER) off_q <= 1'b0;
      if (sel_idr) off_q <= 1'b1;
    end
  end
  // Cycles since the serial clock last rose; saturates so it never wraps.
  always_ff @(posedge core_clk_i) begin
    sck_q <= sck_i;
    if (srst_i) age_q <= 3'h7;
    else if (sck_i && !sck_q) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_idr_reads_zero: assert property (
    s_axi_rvalid_o && s_axi_araddr_i == usi_pkg::ADDR_IRQ_DISABLE_SPI_VIEW
    |-> s_axi_rdata_o == '0) else $error("disable register read nonzero");
  a_mode_follows: assert property (
    wd && s_axi_awaddr_i == usi_pkg::ADDR_MODE
    |-> ##[0:2] mode_o == s_axi_wdata_i[3:0]) else $error("mode not taken");
  a_tick_iso_only: assert property (
    baud_tick_o |-> mode_o == usi_pkg::MODE_ISO7816)
    else $error("tick outside ISO mode");
  a_tick_from_sck: assert property (
    baud_tick_o |-> age_q <= 3'h5) else $error("tick without clock edge");
  a_tick_spacing: assert property (
    baud_tick_o |=> !baud_tick_o [*8]) else $error("ticks too close");
  a_ratio_kept: assert property (
    s_axi_rvalid_o && s_axi_araddr_i == usi_pkg::ADDR_ISO_BAUD_RATIO
    |-> s_axi_rdata_o == {21'h0, rat_q}) else $error("ratio readback");
  a_idr_drops_irq: assert property (
    sel_idr |-> ##[1:3] !irq_o) else $error("irq kept after disable");
  a_irq_stays_off: assert property (
    off_q && $past(off_q, 3) |-> !irq_o) else $error("irq with mask clear");
  c_tick: cover property (baud_tick_o);
  c_irq: cover property ($rose(irq_o));
  c_wp: cover property (wd && wp_q &&
    s_axi_awaddr_i == usi_pkg::ADDR_ISO_BAUD_RATIO);
endmodule

bind usi_usart_slice usi_chk u_chk (.core_clk_i, .srst_i, .s_axi_awaddr_i,
  .s_axi_wdata_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
  .s_axi_rdata_o, .s_axi_rvalid_o, .sck_i, .mode_o, .baud_tick_o, .irq_o);

// ==== usi_card_model.sv ====
// Card side model: serial clock that runs only while asked to.
`timescale 1ns/1ps
module usi_card_model (
  input  wire logic run_i,
  output logic      sck_o
);
  // Half period is no multiple of the core clock, so the phase drifts; the
  // half nanosecond offset keeps every change away from a core clock edge.
  initial begin
    sck_o = 1'b0;
    #0.5;
    forever begin
      #83;
      sck_o = run_i ? ~sck_o : 1'b0;
    end
  end
endmodule

// ==== usi_usart_slice_tb.sv ====
// Self-checking bench for the USART register slice.
`timescale 1ns/1ps
module usi_usart_slice_tb;
  logic        core_clk_i, srst_i, sck_i, sck_run;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, rready_unused_guard_i, irq_o;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, baud_tick_o;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i;
  logic [31:0] s_axi_rdata_o, m;
  logic [3:0]  s_axi_wstrb_i, mode_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  localparam logic [31:0] A_DIS  = usi_pkg::ADDR_IRQ_DISABLE_SPI_VIEW;
  localparam logic [31:0] A_BAUD = usi_pkg::ADDR_ISO_BAUD_RATIO;
  int          err_total, n_compared, ticks, r, i, seed;
  int          bits[9] = '{0, 1, 3, 4, 5, 9, 10, 11, 12};
  usi_pkg::usi_evt_type irq_evt_i;
  usi_usart_slice DUT (.core_clk_i, .srst_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .rready_unused_guard_i,
    .irq_evt_i, .sck_i, .mode_o, .baud_tick_o, .irq_o);
  usi_card_model u_card (.run_i(sck_run), .sck_o(sck_i));
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (baud_tick_o) ticks++;
  // Read results come back in issue order, so the oldest note matches.
  always @(posedge core_clk_i)
    if (s_axi_rvalid_o && rready_unused_guard_i)
      chk("read", exp_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
  // Write responses likewise come back in issue order.
  always @(posedge core_clk_i)
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk("bresp", 34'(bexp_q.pop_front()), 34'(s_axi_bresp_o));
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {usi_pkg::RESP_OKAY, d};
  endfunction
  task automatic chk(input string nm, input logic [33:0] e, s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d,
                    input logic [1:0] e = usi_pkg::RESP_OKAY);
    bexp_q.push_back(e);
    @(posedge core_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) break;
    end
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_i);
    s_axi_araddr_i        <= a;
    s_axi_arvalid_i       <= 1'b1;
    rready_unused_guard_i <= 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) break;
    end
    rready_unused_guard_i <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge core_clk_i);
    chk("irq", 34'(e), 34'(irq_o));
  endtask
  // The clock is stopped low after the last counted rising edge.
  task automatic baud(input int n, input int e);
    ticks = 0;
    sck_run <= 1'b1;
    repeat (n) @(posedge sck_i);
    sck_run <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    chk("ticks", 34'(e), 34'(ticks));
  endtask
  initial begin
    #100_000;
    err_total++;
    give_verdict();
  end
  initial begin
    seed = 88;
    {core_clk_i, sck_run, s_axi_awvalid_i, s_axi_wvalid_i} = '0;
    {s_axi_bready_i, s_axi_arvalid_i, rready_unused_guard_i} = '0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = '0;
    s_axi_wstrb_i = 4'hF;
    irq_evt_i = '0;
    srst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(A_BAUD, ok(32'h0000_0000));
    rd(usi_pkg::ADDR_IMR, ok(32'h0000_0000));
    wr(usi_pkg::ADDR_MODE, 32'h0000_000E);
    wr(usi_pkg::ADDR_IER, usi_pkg::IRQ_VALID);
    wr(A_DIS, 32'h0000_0000);
    m = usi_pkg::IRQ_VALID;
    rd(usi_pkg::ADDR_IMR, ok(m));
    foreach (bits[k]) begin
      wr(A_DIS, 32'h0000_0001 << bits[k]);
      m[bits[k]] = 1'b0;
      rd(usi_pkg::ADDR_IMR, ok(m));
    end
    rd(A_DIS, ok(32'h0000_0000));
    wr(usi_pkg::ADDR_IER, usi_pkg::IRQ_VALID);
    wr(usi_pkg::ADDR_MODE, 32'h0000_0004);
    wr(A_DIS, usi_pkg::IRQ_VALID);
    rd(usi_pkg::ADDR_IMR, ok(32'h0000_0400));
    wr(usi_pkg::ADDR_MODE, 32'h0000_000F);
    wr(A_DIS, usi_pkg::IRQ_VALID);
    rd(usi_pkg::ADDR_IMR, ok(32'h0000_0000));
    rd(32'h4002_4100, {usi_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(32'h4002_4100, 32'h0000_0000, usi_pkg::RESP_SLVERR);
    i = $unsigned($random(seed)) % 9;
    m = 32'h0000_0001 << bits[i];
    wr(usi_pkg::ADDR_IER, m);
    @(posedge core_clk_i);
    irq_evt_i <= usi_pkg::usi_evt_type'(9'h001 << i);
    @(posedge core_clk_i);
    irq_evt_i <= '0;
    irq_is(1'b1);
    wr(A_DIS, usi_pkg::IRQ_VALID);
    irq_is(1'b0);
    wr(usi_pkg::ADDR_IER, m);
    irq_is(1'b1);
    wr(usi_pkg::ADDR_ISR, m);
    irq_is(1'b0);
    wr(usi_pkg::ADDR_MODE, 32'h0000_0004);
    r = 3 + $unsigned($random(seed)) % 6;
    wr(A_BAUD, 32'(r));
    rd(A_BAUD, ok(32'(r)));
    baud(4 * r, 4);
    wr(usi_pkg::ADDR_WPMR, 32'h0000_0001);
    wr(A_BAUD, 32'h0000_0000);
    rd(A_BAUD, ok(32'(r)));
    wr(usi_pkg::ADDR_WPMR, 32'h0000_0000);
    wr(A_BAUD, 32'h0000_0000);
    baud(12, 0);
    wr(A_BAUD, 32'h0000_07FF);
    rd(A_BAUD, ok(32'h0000_07FF));
    give_verdict();
  end
endmodule
